/* hw/obp_pkg.sv */
// Constants shared by the output and bidirectional port logic.
// Assumes a 32-bit AXI4-Lite register bus; each 4-bit register sits in one word at four times its index.
package obp_pkg;
  localparam int ADDR_W = 18;
  localparam int PIO_W = 12;
  // Register indices; byte address is index times four.
  localparam logic [15:0] IDX_CLOCK_OUT = 16'hff06;
  localparam logic [15:0] IDX_P0_FLOAT = 16'hff30;
  localparam logic [15:0] IDX_P0_DATA = 16'hff31;
  localparam logic [15:0] IDX_P1_FLOAT = 16'hff32;
  localparam logic [15:0] IDX_P1_DATA = 16'hff33;
  localparam logic [15:0] IDX_P2_FLOAT = 16'hff34;
  localparam logic [15:0] IDX_P2_DATA = 16'hff35;
  localparam logic [15:0] IDX_PIO0_DIR = 16'hff40;
  localparam logic [15:0] IDX_PIO0_PULL = 16'hff41;
  localparam logic [15:0] IDX_PIO0_DATA = 16'hff42;
  localparam logic [15:0] IDX_PIO1_DIR = 16'hff44;
  localparam logic [15:0] IDX_PIO1_PULL = 16'hff45;
  localparam logic [15:0] IDX_PIO1_DATA = 16'hff46;
  localparam logic [15:0] IDX_PIO2_DIR = 16'hff48;
  localparam logic [15:0] IDX_PIO2_PULL = 16'hff49;
  localparam logic [15:0] IDX_PIO2_DATA = 16'hff4a;
  localparam logic [15:0] IDX_FUNC_SEL = 16'hff70;
  localparam logic [15:0] IDX_TIMER_OUT = 16'hffc1;
  // Field positions.
  localparam int CLK_EN_BIT = 3;
  localparam int TIMER_EN_BIT = 2;
  localparam int CLK_PIN = 3;
  localparam int TIMER_PIN = 2;
  localparam int FUNC_SER_EN_BIT = 0;
  localparam int FUNC_SER_SLAVE_BIT = 1;
  localparam int FUNC_LCD_BIT = 2;
  // Shared pin positions within the 12 bidirectional bits.
  localparam int PIN_SER_IN = 4;
  localparam int PIN_SER_OUT = 5;
  localparam int PIN_SER_CLK = 6;
  localparam int PIN_SER_RDY = 7;
  localparam int PIN_LCD_LINE = 10;
  localparam int PIN_LCD_FRAME = 11;
  localparam int DIV8_BIT = 2;
  localparam int DIV64_BIT = 5;
  // Values after reset.
  localparam logic [3:0] RST_FLOAT = 4'h0;
  localparam logic [3:0] RST_OUT_DATA = 4'hf;
  localparam logic [11:0] RST_DIR = 12'h000;
  localparam logic [11:0] RST_PULL = 12'hfff;
  localparam logic [11:0] RST_PIO_DATA = 12'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] FREQ_HIGH = 2'h3;
  localparam logic [1:0] FREQ_LOW = 2'h2;
  localparam logic [1:0] FREQ_DIV8 = 2'h1;
  localparam logic [1:0] FREQ_DIV64 = 2'h0;
  typedef enum {
    OBP_REG_NONE, OBP_REG_CLOCK_OUT, OBP_REG_P0_FLOAT, OBP_REG_P0_DATA, OBP_REG_P1_FLOAT, OBP_REG_P1_DATA,
    OBP_REG_P2_FLOAT, OBP_REG_P2_DATA, OBP_REG_DIR, OBP_REG_PULL, OBP_REG_PIO_DATA, OBP_REG_FUNC,
    OBP_REG_TIMER_OUT
  } obp_reg_t;
  typedef enum {OBP_ROLE_PORT, OBP_ROLE_IN, OBP_ROLE_OUT} obp_role_t;
endpackage : obp_pkg

/* hw/obp_port.sv */
// Output ports, bidirectional ports and their AXI4-Lite register slave.
// Assumes the timer, serial and LCD blocks run on clock; pins and oscillator clocks are asynchronous.
// What this block does
// RQ1: Float bit set floats the output pin; clear drives data; bit reads back.
// RQ2: All output float bits clear to zero at reset.
// RQ3: Output pin follows its data bit; data reads back as written.
// RQ4: All output data bits set to one at reset.
// RQ5: Clock output enable routes selected clock to pin three, else pin high; resets off.
// RQ6: Two-bit select picks high clock, low clock, low/8 or low/64; resets 00.
// RQ7: Timer output enable routes timer signal to pin two, else pin high; resets off.
// RQ8: With special output on, data zero forces low and float one floats the pin.
// RQ9: Software keeps data one and float zero when a special output is used.
// RQ10: Software starts the high-speed oscillator before selecting it for clock output.
// RQ11: Special output switchover may glitch; nothing guarantees a clean edge.
// RQ12: Twelve bidirectional bits; six shared pins start as plain port bits.
// RQ13: Serial mode maps data in, data out, shift clock and slave ready pins.
// RQ14: Direction bit zero is input, one drives the data bit, per bit.
// RQ15: Port data read gives register in output mode, pin level in input mode.
// RQ16: All direction bits clear at reset, so every bit starts as input.
// RQ17: Direction bits of special or serial pins are plain storage.
// RQ18: Pull-up bit one enables pull-up only in input mode.
// RQ19: All pull-up bits set to one at reset.
// RQ20: Pull-ups of special or serial output pins are storage; serial inputs keep them.
// RQ21: LCD select one makes two port pins carry line sync and frame signals.
module obp_port (
  input wire logic clock,
  input wire logic reset,
  input wire logic [obp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [obp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic high_speed_clock,
  input wire logic low_speed_clock,
  input wire logic timer_signal,
  input wire logic serial_data_output,
  input wire logic serial_shift_clock_out,
  input wire logic serial_slave_ready,
  input wire logic lcd_line_sync,
  input wire logic lcd_frame_signal,
  output logic serial_data_input,
  output logic serial_shift_clock_in,
  output logic [3:0] r0_out,
  output logic [3:0] r0_oe,
  output logic [3:0] r1_out,
  output logic [3:0] r1_oe,
  output logic [3:0] r2_out,
  output logic [3:0] r2_oe,
  input wire logic [obp_pkg::PIO_W-1:0] pio_in,
  output logic [obp_pkg::PIO_W-1:0] pio_out,
  output logic [obp_pkg::PIO_W-1:0] pio_oe,
  output logic [obp_pkg::PIO_W-1:0] pio_pullup
);
  import obp_pkg::*;

  function automatic obp_reg_t obp_decode(input logic [ADDR_W-1:0] addr);
    obp_reg_t sel;
    sel = OBP_REG_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr[ADDR_W-1:2])
        IDX_CLOCK_OUT: sel = OBP_REG_CLOCK_OUT;
        IDX_P0_FLOAT: sel = OBP_REG_P0_FLOAT;
        IDX_P0_DATA: sel = OBP_REG_P0_DATA;
        IDX_P1_FLOAT: sel = OBP_REG_P1_FLOAT;
        IDX_P1_DATA: sel = OBP_REG_P1_DATA;
        IDX_P2_FLOAT: sel = OBP_REG_P2_FLOAT;
        IDX_P2_DATA: sel = OBP_REG_P2_DATA;
        IDX_PIO0_DIR, IDX_PIO1_DIR, IDX_PIO2_DIR: sel = OBP_REG_DIR;
        IDX_PIO0_PULL, IDX_PIO1_PULL, IDX_PIO2_PULL: sel = OBP_REG_PULL;
        IDX_PIO0_DATA, IDX_PIO1_DATA, IDX_PIO2_DATA: sel = OBP_REG_PIO_DATA;
        IDX_FUNC_SEL: sel = OBP_REG_FUNC;
        IDX_TIMER_OUT: sel = OBP_REG_TIMER_OUT;
        default: sel = OBP_REG_NONE;
      endcase
    end
    return sel;
  endfunction

  // Which port group (0..2) a bidirectional register address selects.
  function automatic logic [1:0] obp_group(input logic [ADDR_W-1:0] addr);
    return addr[5:4];
  endfunction

  function automatic obp_role_t obp_role(input int idx, input logic ser_en, input logic slave, input logic lcd);
    obp_role_t role;
    role = OBP_ROLE_PORT;
    if (ser_en && idx == PIN_SER_IN) begin
      role = OBP_ROLE_IN;
    end else if (ser_en && idx == PIN_SER_OUT) begin
      role = OBP_ROLE_OUT;
    end else if (ser_en && idx == PIN_SER_CLK) begin
      role = slave ? OBP_ROLE_IN : OBP_ROLE_OUT;
    end else if (ser_en && slave && idx == PIN_SER_RDY) begin
      role = OBP_ROLE_OUT;
    end else if (lcd && (idx == PIN_LCD_LINE || idx == PIN_LCD_FRAME)) begin
      role = OBP_ROLE_OUT;
    end
    return role;
  endfunction

  logic clock_output_enable;
  logic [1:0] freq_sel;
  logic [3:0] timer_ctrl;
  logic [3:0] port0_float;
  logic [3:0] port0_data;
  logic port1_float_bit;
  logic [3:0] port1_data;
  logic port2_float_bit;
  logic [3:0] port2_data;
  logic [PIO_W-1:0] direction_bits;
  logic [PIO_W-1:0] pullup_bits;
  logic [PIO_W-1:0] pio_data;
  logic serial_enable;
  logic serial_slave;
  logic lcd_sync_out_select;
  logic [PIO_W-1:0] pin_meta;
  logic [PIO_W-1:0] pin_sync;
  logic [1:0] clk_meta;
  logic [1:0] clk_sync;
  logic low_prev;
  logic [5:0] low_div;
  logic wr_en;
  logic rd_en;
  obp_reg_t wr_sel;
  obp_reg_t rd_sel;
  logic [1:0] wr_group;
  logic [3:0] wdata;
  logic [3:0] read_data;
  logic read_err;
  logic selected_clock;
  logic [PIO_W-1:0] pio_read;
  logic [PIO_W-1:0] next_pio_out;
  logic [PIO_W-1:0] next_pio_oe;
  logic [PIO_W-1:0] next_pio_pullup;
  logic [PIO_W-1:0] special_out;

  assign wr_en = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign rd_en = s_axi_arready && s_axi_arvalid;
  assign wr_sel = obp_decode(s_axi_awaddr);
  assign rd_sel = obp_decode(s_axi_araddr);
  assign wr_group = obp_group(s_axi_awaddr);
  assign wdata = s_axi_wdata[3:0];

  // Write address and data are taken together, one cycle after both are offered.
  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == OBP_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_en) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {28'h000_0000, read_data};
        s_axi_rresp <= read_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Unused bits read as zero; port data reads the pin while in input mode.
  always_comb begin
    read_data = 4'h0;
    read_err = 1'b0;
    case (rd_sel)
      OBP_REG_CLOCK_OUT: read_data = {clock_output_enable, 1'b0, freq_sel};
      OBP_REG_P0_FLOAT: read_data = port0_float; // see RQ1
      OBP_REG_P0_DATA: read_data = port0_data; // see RQ3
      OBP_REG_P1_FLOAT: read_data = {3'h0, port1_float_bit};
      OBP_REG_P1_DATA: read_data = port1_data;
      OBP_REG_P2_FLOAT: read_data = {3'h0, port2_float_bit};
      OBP_REG_P2_DATA: read_data = port2_data;
      OBP_REG_DIR: read_data = direction_bits[4*obp_group(s_axi_araddr) +: 4];
      OBP_REG_PULL: read_data = pullup_bits[4*obp_group(s_axi_araddr) +: 4];
      OBP_REG_PIO_DATA: read_data = pio_read[4*obp_group(s_axi_araddr) +: 4]; // see RQ15
      OBP_REG_FUNC: read_data = {1'b0, lcd_sync_out_select, serial_slave, serial_enable};
      OBP_REG_TIMER_OUT: read_data = timer_ctrl;
      default: read_err = 1'b1;
    endcase
  end

  // Output port control; a write with lane 0 disabled changes nothing.
  always_ff @(posedge clock) begin
    if (reset) begin
      clock_output_enable <= 1'b0; // see RQ5
      freq_sel <= FREQ_DIV64; // see RQ6
      timer_ctrl <= 4'h0; // see RQ7
      port0_float <= RST_FLOAT; // see RQ2
      port1_float_bit <= 1'b0;
      port2_float_bit <= 1'b0;
      port0_data <= RST_OUT_DATA; // see RQ4
      port1_data <= RST_OUT_DATA;
      port2_data <= RST_OUT_DATA;
    end else if (wr_en && s_axi_wstrb[0]) begin
      case (wr_sel)
        OBP_REG_CLOCK_OUT: begin
          clock_output_enable <= wdata[CLK_EN_BIT];
          freq_sel <= wdata[1:0];
        end
        OBP_REG_TIMER_OUT: timer_ctrl <= wdata;
        OBP_REG_P0_FLOAT: port0_float <= wdata;
        OBP_REG_P1_FLOAT: port1_float_bit <= wdata[0];
        OBP_REG_P2_FLOAT: port2_float_bit <= wdata[0];
        OBP_REG_P0_DATA: port0_data <= wdata;
        OBP_REG_P1_DATA: port1_data <= wdata;
        OBP_REG_P2_DATA: port2_data <= wdata;
        default: ;
      endcase
    end
  end

  // Bidirectional port registers; every bit starts as a plain input with pull-up.
  always_ff @(posedge clock) begin
    if (reset) begin
      direction_bits <= RST_DIR; // see RQ16
      pullup_bits <= RST_PULL; // see RQ19
      pio_data <= RST_PIO_DATA;
      serial_enable <= 1'b0; // see RQ12
      serial_slave <= 1'b0;
      lcd_sync_out_select <= 1'b0;
    end else if (wr_en && s_axi_wstrb[0]) begin
      case (wr_sel)
        OBP_REG_DIR: direction_bits[4*wr_group +: 4] <= wdata;
        OBP_REG_PULL: pullup_bits[4*wr_group +: 4] <= wdata;
        OBP_REG_PIO_DATA: pio_data[4*wr_group +: 4] <= wdata;
        OBP_REG_FUNC: begin
          serial_enable <= wdata[FUNC_SER_EN_BIT];
          serial_slave <= wdata[FUNC_SER_SLAVE_BIT];
          lcd_sync_out_select <= wdata[FUNC_LCD_BIT];
        end
        default: ;
      endcase
    end
  end

  // Pins and oscillator clocks are asynchronous, so each passes two flip-flops.
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_meta <= '0;
      pin_sync <= '0;
      clk_meta <= 2'h0;
      clk_sync <= 2'h0;
      low_prev <= 1'b0;
    end else begin
      pin_meta <= pio_in;
      pin_sync <= pin_meta;
      clk_meta <= {high_speed_clock, low_speed_clock};
      clk_sync <= clk_meta;
      low_prev <= clk_sync[0];
    end
  end

  // The low clock is divided by counting its sampled rising edges.
  always_ff @(posedge clock) begin
    if (reset) begin
      low_div <= 6'h00;
    end else if (clk_sync[0] && !low_prev) begin
      low_div <= low_div + 6'h01;
    end
  end

  // A high clock near the core rate is aliased by sampling; only slow oscillators come out clean.
  always_comb begin
    case (freq_sel)
      FREQ_HIGH: selected_clock = clk_sync[1];
      FREQ_LOW: selected_clock = clk_sync[0];
      FREQ_DIV8: selected_clock = low_div[DIV8_BIT];
      default: selected_clock = low_div[DIV64_BIT];
    endcase // see RQ6
  end

  // Enables are not aligned to the clock edges, so switching may leave a short pulse.
  always_ff @(posedge clock) begin
    if (reset) begin
      r0_out <= RST_OUT_DATA;
      r1_out <= RST_OUT_DATA;
      r2_out <= RST_OUT_DATA;
      r0_oe <= 4'hf;
      r1_oe <= 4'hf;
      r2_oe <= 4'hf;
    end else begin
      r0_out[1:0] <= port0_data[1:0]; // see RQ3
      r0_out[TIMER_PIN] <= port0_data[TIMER_PIN] & (timer_ctrl[TIMER_EN_BIT] ? timer_signal : 1'b1); // see RQ7
      r0_out[CLK_PIN] <= port0_data[CLK_PIN] & (clock_output_enable ? selected_clock : 1'b1); // see RQ5, RQ8, RQ11
      r1_out <= port1_data;
      r2_out <= port2_data;
      r0_oe <= ~port0_float; // see RQ1, RQ8
      r1_oe <= {4{~port1_float_bit}};
      r2_oe <= {4{~port2_float_bit}};
    end
  end

  always_comb begin
    special_out = '0;
    special_out[PIN_SER_OUT] = serial_data_output;
    special_out[PIN_SER_CLK] = serial_shift_clock_out;
    special_out[PIN_SER_RDY] = serial_slave_ready;
    special_out[PIN_LCD_LINE] = lcd_line_sync; // see RQ21
    special_out[PIN_LCD_FRAME] = lcd_frame_signal;
  end

  for (genvar i = 0; i < PIO_W; i++) begin : g_pin
    obp_role_t role;
    assign role = obp_role(i, serial_enable, serial_slave, lcd_sync_out_select); // see RQ13, RQ21
    // Direction bits of a taken pin are only stored; its pull-up bits are only stored on outputs and still act on serial inputs.
    assign next_pio_oe[i] = (role == OBP_ROLE_OUT) || (role == OBP_ROLE_PORT && direction_bits[i]); // see RQ14, RQ17
    assign next_pio_out[i] = (role == OBP_ROLE_OUT) ? special_out[i] : pio_data[i];
    assign next_pio_pullup[i] = (role == OBP_ROLE_IN) ? pullup_bits[i] :
      (role == OBP_ROLE_PORT) ? (pullup_bits[i] & ~direction_bits[i]) : 1'b0; // see RQ18, RQ20
    assign pio_read[i] = (role == OBP_ROLE_PORT && direction_bits[i]) ? pio_data[i] : pin_sync[i]; // see RQ15
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pio_out <= RST_PIO_DATA;
      pio_oe <= '0;
      pio_pullup <= RST_PULL;
      serial_data_input <= 1'b0;
      serial_shift_clock_in <= 1'b0;
    end else begin
      pio_out <= next_pio_out;
      pio_oe <= next_pio_oe;
      pio_pullup <= next_pio_pullup;
      serial_data_input <= pin_sync[PIN_SER_IN]; // see RQ13
      serial_shift_clock_in <= pin_sync[PIN_SER_CLK];
    end
  end

  a_float_after_reset: assert property (@(posedge clock) $fell(reset) |-> ##1 // see RQ2
    (r0_oe == 4'hf && r1_oe == 4'hf && r2_oe == 4'hf && r1_out == 4'hf)) else $error("outputs not driven high after reset");
  a_float_write_pin: assert property (@(posedge clock) disable iff (reset) // see RQ1
    (wr_en && s_axi_wstrb[0] && wr_sel == OBP_REG_P0_FLOAT) |-> ##2 (r0_oe == ~$past(s_axi_wdata[3:0], 2)))
    else $error("float write did not reach pins");
  a_data_write_pin: assert property (@(posedge clock) disable iff (reset) // see RQ3
    (wr_en && s_axi_wstrb[0] && wr_sel == OBP_REG_P1_DATA) |-> ##2 (r1_out == $past(s_axi_wdata[3:0], 2)))
    else $error("data write did not reach pins");
  a_clock_pin_high: assert property (@(posedge clock) disable iff (reset) // see RQ5
    (!clock_output_enable && port0_data[CLK_PIN]) |=> r0_out[CLK_PIN]) else $error("clock pin not high when off");
  a_clock_low_sel: assert property (@(posedge clock) disable iff (reset) // see RQ6
    (clock_output_enable && port0_data[CLK_PIN] && freq_sel == FREQ_LOW) |=> (r0_out[CLK_PIN] == $past(clk_sync[0])))
    else $error("low clock not selected");
  a_special_data_low: assert property (@(posedge clock) disable iff (reset) // see RQ8
    (!port0_data[TIMER_PIN] && !port0_data[CLK_PIN]) |=> (!r0_out[TIMER_PIN] && !r0_out[CLK_PIN]))
    else $error("data zero did not force pin low");
  a_timer_pin_route: assert property (@(posedge clock) disable iff (reset) // see RQ7
    (timer_ctrl[TIMER_EN_BIT] && port0_data[TIMER_PIN]) |=> (r0_out[TIMER_PIN] == $past(timer_signal)))
    else $error("timer signal not routed");
  a_input_no_drive: assert property (@(posedge clock) disable iff (reset) // see RQ14
    !direction_bits[0] |=> !pio_oe[0]) else $error("input bit driven");
  a_pullup_output_off: assert property (@(posedge clock) disable iff (reset) // see RQ18
    (direction_bits[1] && !serial_enable) |=> !pio_pullup[1]) else $error("pull-up active in output mode");
  a_serial_out_route: assert property (@(posedge clock) disable iff (reset) // see RQ13
    serial_enable |=> (pio_oe[PIN_SER_OUT] && pio_out[PIN_SER_OUT] == $past(serial_data_output)))
    else $error("serial output not routed");
  a_lcd_sync_route: assert property (@(posedge clock) disable iff (reset) // see RQ21
    lcd_sync_out_select |=> (pio_oe[PIN_LCD_FRAME] && pio_out[PIN_LCD_FRAME] == $past(lcd_frame_signal)))
    else $error("lcd frame not routed");
endmodule // obp_port

/* tb/obp_pins.sv */
// Pin model for the twelve bidirectional port bits.
// Assumes the bench drives ext_en and ext_val at the rising clock edge.
module obp_pins (
  input wire logic clock,
  input wire logic [11:0] pio_out,
  input wire logic [11:0] pio_oe,
  input wire logic [11:0] pio_pullup,
  input wire logic [11:0] ext_en,
  input wire logic [11:0] ext_val,
  output logic [11:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] last;
  // A floating pin shows the inverse of its last level, so a stale value never passes for a match.
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (pio_oe[i]) pin[i] = pio_out[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (pio_pullup[i]) pin[i] = 1'b1;
      else pin[i] = ~last[i];
    end
  end
  always_ff @(posedge clock) last <= pin;
endmodule // obp_pins

/* tb/obp_port_tb.sv */
// Self-checking bench for the output and bidirectional port logic.
// Assumes one-word AXI4-Lite registers at four times their index.
module obp_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import obp_pkg::*;
  logic clock = 1'b0, reset = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic high_speed_clock = 1'b0, low_speed_clock = 1'b0, timer_signal = 1'b0;
  logic serial_data_output = 1'b0, lcd_line_sync = 1'b0, lcd_frame_signal = 1'b0, serial_data_input;
  logic serial_shift_clock_out = 1'b0, serial_slave_ready = 1'b0, serial_shift_clock_in;
  logic [3:0] r0_out, r0_oe, r1_out, r1_oe, r2_out, r2_oe, slow_cnt = 4'h0;
  logic [11:0] pio_in, pio_out, pio_oe, pio_pullup, ext_en = '0, ext_val = '0;
  int n_mismatch = 0, total_checks = 0;
  always #2 clock = ~clock;
  // The fast oscillator runs from time zero, long before it is selected.
  always @(posedge clock) begin
    high_speed_clock <= ~high_speed_clock;
    slow_cnt <= slow_cnt + 4'h1;
    if (slow_cnt[2:0] == 3'h7) low_speed_clock <= ~low_speed_clock;
  end
  obp_port obp_port_i (.clock, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_speed_clock, .low_speed_clock,
    .timer_signal, .serial_data_output, .serial_shift_clock_out, .serial_slave_ready, .lcd_line_sync,
    .lcd_frame_signal, .serial_data_input, .serial_shift_clock_in, .r0_out, .r0_oe, .r1_out, .r1_oe, .r2_out,
    .r2_oe, .pio_in, .pio_out, .pio_oe, .pio_pullup);
  obp_pins obp_pins_i (.clock, .pio_out, .pio_oe, .pio_pullup, .ext_en, .ext_val, .pin(pio_in));
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [3:0] d);
    logic aw_done, w_done;
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {idx, 2'b00, 28'h0, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    aw_done = 1'b0;
    w_done = 1'b0;
    // Each channel is released at its own ready; only the watchdog ends a hung wait.
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) aw_done = 1'b1;
      if (s_axi_wready === 1'b1) w_done = 1'b1;
      if (aw_done) s_axi_awvalid <= 1'b0;
      if (w_done) s_axi_wvalid <= 1'b0;
    end while (!(aw_done && w_done));
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, RESP_OKAY);
    repeat (2) @(posedge clock);
  endtask
  task automatic rd(input logic [15:0] idx, output logic [33:0] rd_word);
    @(posedge clock);
    s_axi_araddr <= {idx, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd_word = {s_axi_rresp, s_axi_rdata};
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [3:0] exp);
    logic [33:0] w;
    rd(idx, w);
    chk(w, {RESP_OKAY, 28'h0, exp});
  endtask
  task automatic t_reset;
    chk({r0_out, r0_oe, r1_out, r1_oe, r2_out, r2_oe}, 24'hffffff);
    chk({pio_oe, pio_pullup}, 24'h000fff);
    rchk(IDX_P0_DATA, 4'hf);
    rchk(IDX_P1_FLOAT, 4'h0);
    rchk(IDX_CLOCK_OUT, 4'h0);
    rchk(IDX_TIMER_OUT, 4'h0);
    rchk(IDX_PIO1_DIR, 4'h0);
    rchk(IDX_PIO2_PULL, 4'hf);
    $display("t_reset done");
  endtask
  task automatic t_out;
    logic [33:0] w;
    wr(IDX_P1_DATA, 4'h5);
    chk(r1_out, 4'h5);
    rchk(IDX_P1_DATA, 4'h5);
    wr(IDX_P1_FLOAT, 4'h1);
    chk(r1_oe, 4'h0);
    rchk(IDX_P1_FLOAT, 4'h1);
    wr(IDX_P1_FLOAT, 4'h0);
    chk(r1_oe, 4'hf);
    rd(16'h0000, w);
    chk(w, {RESP_SLVERR, 32'h0});
    $display("t_out done");
  endtask
  task automatic t_timer;
    wr(IDX_TIMER_OUT, 4'h4);
    timer_signal <= 1'b0;
    repeat (3) @(posedge clock);
    chk(r0_out, 4'hb);
    timer_signal <= 1'b1;
    repeat (3) @(posedge clock);
    chk(r0_out, 4'hf);
    wr(IDX_P0_DATA, 4'h3);
    chk(r0_out, 4'h3);
    wr(IDX_P0_FLOAT, 4'h4);
    chk(r0_oe, 4'hb);
    wr(IDX_P0_FLOAT, 4'h0);
    wr(IDX_P0_DATA, 4'hf);
    timer_signal <= 1'b0;
    wr(IDX_TIMER_OUT, 4'h0);
    chk(r0_out, 4'hf);
    $display("t_timer done");
  endtask
  task automatic t_clock;
    int exp_t[4] = '{2, 16, 128, 1024};
    int cnt;
    logic prev;
    for (int s = 0; s < 4; s++) begin
      wr(IDX_CLOCK_OUT, 4'h8 | 4'(s));
      repeat (70) @(posedge clock);
      cnt = 0;
      prev = r0_out[3];
      repeat (1024) begin
        @(posedge clock);
        if (r0_out[3] !== prev) cnt++;
        prev = r0_out[3];
      end
      chk(cnt >= exp_t[s] * 7 / 8 && cnt <= exp_t[s] * 9 / 8 + 1, 1'b1);
    end
    wr(IDX_CLOCK_OUT, 4'h0);
    repeat (4) @(posedge clock);
    chk(r0_out[3], 1'b1);
    $display("t_clock done");
  endtask
  task automatic t_pio;
    wr(IDX_PIO0_DIR, 4'hf);
    wr(IDX_PIO0_DATA, 4'ha);
    chk({pio_oe[3:0], pio_out[3:0], pio_pullup[3:0]}, 12'hfa0);
    rchk(IDX_PIO0_DATA, 4'ha);
    wr(IDX_PIO0_DIR, 4'h5);
    {ext_en, ext_val} <= {12'h00a, 12'h000};
    chk({pio_oe[3:0], pio_pullup[3:0]}, 8'h5a);
    rchk(IDX_PIO0_DATA, 4'h0);
    ext_en <= 12'h000;
    rchk(IDX_PIO0_DATA, 4'ha);
    wr(IDX_PIO0_PULL, 4'h0);
    chk(pio_pullup[3:0], 4'h0);
    $display("t_pio done");
  endtask
  task automatic t_func;
    wr(IDX_FUNC_SEL, 4'h4);
    {lcd_line_sync, lcd_frame_signal} <= 2'b10;
    repeat (3) @(posedge clock);
    chk({pio_oe[11:10], pio_out[11:10]}, 4'hd);
    {lcd_line_sync, lcd_frame_signal} <= 2'b01;
    repeat (3) @(posedge clock);
    chk(pio_out[11:10], 2'b10);
    wr(IDX_FUNC_SEL, 4'h1);
    serial_data_output <= 1'b1;
    serial_shift_clock_out <= 1'b1;
    {ext_en, ext_val} <= {12'h010, 12'h010};
    repeat (4) @(posedge clock);
    chk({pio_oe[6:4], pio_out[5], serial_data_input, pio_pullup[5:4]}, 7'h6d);
    chk({pio_oe[7], pio_out[6]}, 2'b01);
    // Slave mode turns the shift clock pin into an input and adds the ready output.
    wr(IDX_FUNC_SEL, 4'h3);
    serial_slave_ready <= 1'b1;
    {ext_en, ext_val} <= {12'h050, 12'h010};
    repeat (4) @(posedge clock);
    chk({pio_oe[7:6], pio_out[7], serial_shift_clock_in, pio_pullup[6]}, 5'h15);
    wr(IDX_FUNC_SEL, 4'h0);
    chk(pio_oe[11:4], 8'h00);
    $display("t_func done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_out();
    t_timer();
    t_clock();
    t_pio();
    t_func();
    end_sim();
  end
  // The run needs about 4600 cycles; the watchdog allows 25000, about five times that.
  initial begin
    #100000;
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule // obp_port_tb
